// ===== hw/aqh_map.vh
`ifndef AQH_MAP_VH
`define AQH_MAP_VH
// ----------------------------------------
// register byte offsets (low address byte)
// ----------------------------------------
`define AQH_OFF_TXQ_MID 8'h88
`define AQH_OFF_TXQ_FIN 8'h8C
`define AQH_OFF_TXP_MID 8'h90
`define AQH_OFF_TXP_FIN 8'h94
`define AQH_OFF_RXQ     8'h98
`define AQH_OFF_RXP     8'h9C
`define AQH_OFF_ACK     8'hA0
`define AQH_OFF_EN      8'hA4
// ----------------------------------------
// event acknowledge bit positions
// ----------------------------------------
`define AQH_B_RXP_FULL  16
`define AQH_B_RXQ_FULL  15
`define AQH_B_SELF_ID   14
`define AQH_B_RX_FINAL  12
`define AQH_B_RX_FAULT  10
`define AQH_B_RX_READY  8
`define AQH_B_TIMEOUT   7
`define AQH_B_RESP_ARR  6
`define AQH_B_TX_FULL   4
`define AQH_B_TX_FAULT  2
`define AQH_B_TX_DRAIN  0
// ----------------------------------------
// widths, masks and reset values
// ----------------------------------------
`define AQH_ACK_W       17
`define AQH_ACK_RST     17'h00C00
`define AQH_EN_RST      17'h00000
`define AQH_W1C_MASK    17'h18CFF
`define AQH_RX_RST      32'h00000000
`endif

// ===== hw/aqh_host_access.v
// Operation
// R1: request-mid write loads quadlet, clears request drained
// R2: request-final write loads last quadlet, clears drained
// R3: response-mid write loads quadlet, clears response drained
// R4: response-final write loads last quadlet, clears drained
// R5: request read pops quadlet, clears ready; resets zero
// R6: response read pops quadlet, clears ready flag
// R7: receive response full sets sticky bit
// R8: receive request full sets sticky bit
// R9: self-ID flag only after bus reset
// R10: final-quadlet flags clear when quadlet read
// R11: read faults on error/bus reset block reads
// R12: word-ready flags clear when quadlet read
// R13: split timeout sets sticky bit, write one clears
// R14: solicited response in time sets sticky bit
// R15: transmit queue full sets per-queue sticky bits
// R16: transmit transfer error sets write-fault bits
// R17: drained bits set when transfer register empties
// R18: acknowledge bits 31 to 17 read zero
// R19: enable register gates events, resets zero
// R20: interrupt while any enabled event bit set
`timescale 1ns/1ps
`include "aqh_map.vh"

module aqh_host_access #(
	parameter ACKW = `AQH_ACK_W
) (
	// clock and reset
	input  wire        mclk,
	input  wire        sys_rst,
	// ahb-lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output wire [31:0] hrdata,
	// transmit request queue push
	output wire [31:0] tx_req_data,
	output wire        tx_req_final,
	output wire        tx_req_valid,
	input  wire        tx_req_ready,
	// transmit response queue push
	output wire [31:0] tx_resp_data,
	output wire        tx_resp_final,
	output wire        tx_resp_valid,
	input  wire        tx_resp_ready,
	// receive request queue pop
	input  wire [31:0] rx_req_data,
	input  wire        rx_req_final,
	input  wire        rx_req_selfid,
	input  wire        rx_req_valid,
	output wire        rx_req_ready,
	// receive response queue pop
	input  wire [31:0] rx_resp_data,
	input  wire        rx_resp_final,
	input  wire        rx_resp_valid,
	output wire        rx_resp_ready,
	// queue full levels
	input  wire        txq_req_full,
	input  wire        txq_resp_full,
	input  wire        rxq_req_full,
	input  wire        rxq_resp_full,
	// transfer error and link event pulses
	input  wire        tx_req_xfer_err,
	input  wire        tx_resp_xfer_err,
	input  wire        rx_req_xfer_err,
	input  wire        rx_resp_xfer_err,
	input  wire        bus_reset,
	input  wire        split_timeout,
	input  wire        resp_in_time,
	// interrupt request
	output wire        irq
);

// ----------------------------------------
// word decode
// ----------------------------------------
function hit;
	input [7:0] a;
	input [7:0] o;
	begin
		hit = (a[7:2] == o[7:2]);
	end
endfunction

// ----------------------------------------
// ahb address and data phase
// ----------------------------------------
reg            ready_q;
reg     [31:0] rdata_q;
reg            dph_wr;
reg      [7:0] dph_addr;
reg     [31:0] rd_val;
reg            resp_q;
wire           acc;
wire           rd_acc;
wire           wr_ack;
wire           wr_en;

// reads and pops act in the address phase: a read issued
// right behind a write to the same word sees the old value
assign acc       = hsel & htrans[1] & hready;
assign rd_acc    = acc & ~hwrite;
assign wr_ack    = dph_wr & hit(dph_addr, `AQH_OFF_ACK);
assign wr_en     = dph_wr & hit(dph_addr, `AQH_OFF_EN);
assign hreadyout = ready_q;
assign hresp     = resp_q;
assign hrdata    = rdata_q;

// capture write address; data follows a cycle later
always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		dph_wr   <= 1'b0;
		dph_addr <= 8'h00;
		ready_q  <= 1'b1;
	end else begin
		ready_q  <= 1'b1;     // zero wait states
		if (hready) begin
			dph_wr   <= acc & hwrite;
			dph_addr <= haddr[7:0];
		end
	end
end

// ----------------------------------------
// bus response
// ----------------------------------------
// the slave never errors or stalls; the okay code
// still leaves a flop like every other bus output
always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		resp_q <= 1'b0;
	end else begin
		resp_q <= 1'b0; // okay only
	end
end

// ----------------------------------------
// per-queue state
// ----------------------------------------
reg     [31:0] tx_dat [0:1];
reg      [1:0] tx_fin;
reg      [1:0] tx_pend;
reg     [31:0] rx_dat [0:1];
reg      [1:0] rx_fin;
reg      [1:0] rx_av;
reg      [1:0] rx_rdy;
reg      [1:0] rx_sid;
reg            sid_win;
reg [ACKW-1:0] stk;
reg [ACKW-1:0] en;
reg            irq_q;
reg      [3:0] full_prev;
wire     [1:0] txr;
wire     [1:0] rxv;
wire     [1:0] rxf;
wire     [1:0] rxs;
wire     [1:0] tw_ok;
wire     [1:0] tw_bad;
wire     [1:0] tx_hs;
wire     [1:0] rx_pop;
wire     [1:0] rx_take;
wire     [1:0] next_av;
wire     [3:0] full_lvl;
wire     [3:0] full_rise;
wire    [31:0] rxd_in [0:1];

assign txr       = {tx_resp_ready, tx_req_ready};
assign rxv       = {rx_resp_valid, rx_req_valid};
assign rxf       = {rx_resp_final, rx_req_final};
assign rxs       = {1'b0, rx_req_selfid};
assign rxd_in[0] = rx_req_data;
assign rxd_in[1] = rx_resp_data;

assign tx_req_data   = tx_dat[0];
assign tx_req_final  = tx_fin[0];
assign tx_req_valid  = tx_pend[0];
assign tx_resp_data  = tx_dat[1];
assign tx_resp_final = tx_fin[1];
assign tx_resp_valid = tx_pend[1];
assign rx_req_ready  = rx_rdy[0];
assign rx_resp_ready = rx_rdy[1];
assign irq           = irq_q;

// channel 0 is request, channel 1 is response
genvar c;
generate
for (c = 0; c < 2; c = c + 1) begin : g_ch
	localparam [7:0] O_MID = (c == 0) ?
		`AQH_OFF_TXQ_MID : `AQH_OFF_TXP_MID;
	localparam [7:0] O_FIN = (c == 0) ?
		`AQH_OFF_TXQ_FIN : `AQH_OFF_TXP_FIN;
	localparam [7:0] O_RX  = (c == 0) ?
		`AQH_OFF_RXQ : `AQH_OFF_RXP;
	wire tw_mid;
	wire tw_fin;

	assign tw_mid    = dph_wr & hit(dph_addr, O_MID);
	assign tw_fin    = dph_wr & hit(dph_addr, O_FIN);
	// a write onto a full transfer register is dropped
	assign tw_ok[c]  = (tw_mid | tw_fin) & ~tx_pend[c];
	assign tw_bad[c] = (tw_mid | tw_fin) & tx_pend[c];
	assign tx_hs[c]  = tx_pend[c] & txr[c];
	// blocked while the read fault bit stands; an empty
	// register is not popped and reads back stale data
	assign rx_pop[c] = rd_acc & hit(haddr[7:0], O_RX) & rx_av[c] &
		~stk[`AQH_B_RX_FAULT + c]; // R11
	assign rx_take[c] = rx_rdy[c] & rxv[c];
	assign next_av[c] = rx_take[c] | (rx_av[c] & ~rx_pop[c]);

	// transmit transfer register toward its queue
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_dat[c]  <= 32'h00000000;
			tx_fin[c]  <= 1'b0;
			tx_pend[c] <= 1'b0;
		end else if (tw_ok[c]) begin
			tx_dat[c]  <= hwdata;  // R1 R3
			tx_fin[c]  <= tw_fin;  // R2 R4
			tx_pend[c] <= 1'b1;
		end else if (tx_hs[c]) begin
			tx_pend[c] <= 1'b0;
		end
	end

	// receive transfer register from its queue
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_dat[c] <= `AQH_RX_RST; // R5
			rx_fin[c] <= 1'b0;
			rx_sid[c] <= 1'b0;
			rx_av[c]  <= 1'b0;
			rx_rdy[c] <= 1'b0;
		end else begin
			rx_av[c]  <= next_av[c]; // R12
			rx_rdy[c] <= ~next_av[c];
			if (rx_take[c]) begin
				rx_dat[c] <= rxd_in[c];
				rx_fin[c] <= rxf[c];
				rx_sid[c] <= rxs[c] & sid_win; // R9
			end else if (rx_pop[c]) begin
				rx_fin[c] <= 1'b0; // R10
				rx_sid[c] <= 1'b0; // R9
			end
		end
	end
end
endgenerate

// ----------------------------------------
// self-id window after bus reset
// ----------------------------------------
// closes on the first ordinary request quadlet, so
// later phy packets never raise the self-id flag
always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		sid_win <= 1'b0;
	end else if (bus_reset) begin
		sid_win <= 1'b1; // R9
	end else if (rx_take[0] & ~rx_req_selfid) begin
		sid_win <= 1'b0;
	end
end

// ----------------------------------------
// sticky event bits
// ----------------------------------------
reg [ACKW-1:0] ev_set;
reg [ACKW-1:0] ev_clr;
reg [ACKW-1:0] next_stk;
reg [ACKW-1:0] ack_view;

// a queue already full when reset lifts raises
// its event on the first edge after
assign full_lvl  = {rxq_resp_full, rxq_req_full,
	txq_resp_full, txq_req_full};
assign full_rise = full_lvl & ~full_prev;

// sets win over clears in the same cycle
always @* begin
	ev_set = {ACKW{1'b0}};
	ev_set[`AQH_B_RXP_FULL] = full_rise[3]; // R7
	ev_set[`AQH_B_RXQ_FULL] = full_rise[2]; // R8
	ev_set[`AQH_B_RX_FAULT] =
		rx_req_xfer_err | bus_reset; // R11
	ev_set[`AQH_B_RX_FAULT + 1] =
		rx_resp_xfer_err | bus_reset; // R11
	ev_set[`AQH_B_TIMEOUT]  = split_timeout; // R13
	ev_set[`AQH_B_RESP_ARR] = resp_in_time;  // R14
	ev_set[`AQH_B_TX_FULL]     = full_rise[0]; // R15
	ev_set[`AQH_B_TX_FULL + 1] = full_rise[1]; // R15
	ev_set[`AQH_B_TX_FAULT] =
		tx_req_xfer_err | tw_bad[0]; // R16
	ev_set[`AQH_B_TX_FAULT + 1] =
		tx_resp_xfer_err | tw_bad[1]; // R16
	ev_set[`AQH_B_TX_DRAIN]     = tx_hs[0]; // R17
	ev_set[`AQH_B_TX_DRAIN + 1] = tx_hs[1]; // R17
	ev_clr = {ACKW{1'b0}};
	if (wr_ack) begin
		ev_clr = hwdata[ACKW-1:0] & `AQH_W1C_MASK;
	end
	// loading a transfer register drops its drained bit
	ev_clr[`AQH_B_TX_DRAIN]     =
		ev_clr[`AQH_B_TX_DRAIN] | tw_ok[0]; // R1 R2
	ev_clr[`AQH_B_TX_DRAIN + 1] =
		ev_clr[`AQH_B_TX_DRAIN + 1] | tw_ok[1]; // R3 R4
	next_stk = ((stk & ~ev_clr) | ev_set) & `AQH_W1C_MASK;
end

// status bits that follow the receive registers
always @* begin
	ack_view = stk;
	ack_view[`AQH_B_SELF_ID]      = rx_sid[0];
	ack_view[`AQH_B_RX_FINAL]     = rx_fin[0]; // R10
	ack_view[`AQH_B_RX_FINAL + 1] = rx_fin[1]; // R10
	ack_view[`AQH_B_RX_READY]     = rx_av[0];  // R12
	ack_view[`AQH_B_RX_READY + 1] = rx_av[1];  // R12
end

// sticky register, enables, edge history, interrupt
always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		stk       <= `AQH_ACK_RST;
		en        <= `AQH_EN_RST; // R19
		full_prev <= 4'h0;
		irq_q     <= 1'b0;
	end else begin
		stk       <= next_stk;
		full_prev <= full_lvl;
		if (wr_en) begin
			en <= hwdata[ACKW-1:0]; // R19
		end
		// one cycle behind the event bits it reflects
		irq_q <= |(ack_view & en); // R20
	end
end

// ----------------------------------------
// read data
// ----------------------------------------
// faulted queues read zero; write-only and unmapped
// words read zero as well
always @* begin
	rd_val = 32'h00000000;
	if (hit(haddr[7:0], `AQH_OFF_RXQ)) begin
		if (~stk[`AQH_B_RX_FAULT]) begin
			rd_val = rx_dat[0]; // R5
		end
	end else if (hit(haddr[7:0], `AQH_OFF_RXP)) begin
		if (~stk[`AQH_B_RX_FAULT + 1]) begin
			rd_val = rx_dat[1]; // R6
		end
	end else if (hit(haddr[7:0], `AQH_OFF_ACK)) begin
		rd_val = {{(32-ACKW){1'b0}}, ack_view}; // R18
	end else if (hit(haddr[7:0], `AQH_OFF_EN)) begin
		rd_val = {{(32-ACKW){1'b0}}, en};
	end
end

always @(posedge mclk or posedge sys_rst) begin
	if (sys_rst) begin
		rdata_q <= 32'h00000000;
	end else if (rd_acc) begin
		rdata_q <= rd_val;
	end else begin
		rdata_q <= 32'h00000000;
	end
end

endmodule // aqh_host_access

// ===== testbench/aqh_checker_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// bus and queue handshake checks
// ------------------------------
module aqh_checker (
	// clock, reset and bus
	input wire        mclk,
	input wire        sys_rst,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] hrdata,
	// queue handshakes
	input wire [31:0] tx_req_data,
	input wire        tx_req_final,
	input wire        tx_req_valid,
	input wire        tx_req_ready,
	input wire        tx_resp_final,
	input wire        tx_resp_valid,
	input wire        rx_req_valid,
	input wire        rx_req_ready
);
	// address phase decode, low byte only as the slave does
	wire       go = hsel & htrans[1] & hready;
	wire [7:0] a  = haddr[7:0];
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	a_txq_load: assert property (!$past(go) && go && hwrite
		&& a == 8'h88 && !tx_req_valid |-> ##2 tx_req_valid
		&& !tx_req_final && tx_req_data == $past(hwdata))
		else $error("request load wrong");
	a_txp_final: assert property (!$past(go) && go && hwrite
		&& a == 8'h94 && !tx_resp_valid |-> ##2 tx_resp_valid
		&& tx_resp_final) else $error("response final load wrong");
	a_push_drop: assert property (tx_req_valid && tx_req_ready
		|=> !tx_req_valid) else $error("valid held after push");
	a_tx_hold: assert property (tx_req_valid && !tx_req_ready
		|=> tx_req_valid && $stable(tx_req_data))
		else $error("quadlet lost while waiting");
	a_rx_take: assert property (rx_req_valid && rx_req_ready
		|=> !rx_req_ready) else $error("ready held after take");
	a_rd_idle: assert property (!(go && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside data phase");
	a_ack_upper: assert property (go && !hwrite && a == 8'hA0
		|=> hrdata[31:17] == 15'h0) else $error("unused bits not zero");
	a_wo_zero: assert property (go && !hwrite && a >= 8'h88
		&& a <= 8'h94 |=> hrdata == 32'h0) else $error("write-only read");
endmodule // aqh_checker

bind aqh_host_access aqh_checker aqh_checker_i (.mclk, .sys_rst, .hsel,
	.haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
	.hrdata, .tx_req_data, .tx_req_final, .tx_req_valid, .tx_req_ready,
	.tx_resp_final, .tx_resp_valid, .rx_req_valid, .rx_req_ready);

// ===== testbench/test_aqh_host_access.sv
`timescale 1ns/1ps
// ------------------------------
// host access bench
// ------------------------------
module test_aqh_host_access;
	// stimulus, link pulses packed as one vector
	reg         mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0;
	reg  [31:0] haddr = 0, hwdata = 0, rxd = 0, r;
	reg  [1:0]  htrans = 0, txr = 0, rxv = 0;
	reg         rxf = 0, sid = 0;
	reg  [10:0] ev = 0;
	reg  [15:0] cyc = 0;
	integer     n_errors = 0, checks_done = 0;
	wire [31:0] hrdata, tx_req_data, tx_resp_data;
	wire        hreadyout, tx_req_final, tx_req_valid, tx_resp_final;
	wire        tx_resp_valid, irq;
	wire [1:0]  rxr;
	aqh_host_access aqh_host_access_i (.mclk, .sys_rst, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hresp(), .hrdata, .tx_req_data, .tx_req_final,
		.tx_req_valid, .tx_req_ready(txr[0]), .tx_resp_data,
		.tx_resp_final, .tx_resp_valid, .tx_resp_ready(txr[1]),
		.rx_req_data(rxd), .rx_req_final(rxf), .rx_req_selfid(sid),
		.rx_req_valid(rxv[0]), .rx_req_ready(rxr[0]),
		.rx_resp_data(rxd), .rx_resp_final(rxf),
		.rx_resp_valid(rxv[1]), .rx_resp_ready(rxr[1]),
		.txq_req_full(ev[6]), .txq_resp_full(ev[7]), .rxq_req_full(ev[8]),
		.rxq_resp_full(ev[9]), .tx_req_xfer_err(ev[2]),
		.tx_resp_xfer_err(ev[3]), .rx_req_xfer_err(ev[4]),
		.rx_resp_xfer_err(ev[5]), .bus_reset(ev[10]),
		.split_timeout(ev[1]), .resp_in_time(ev[0]), .irq);
	// free-running clock and a hang guard
	initial forever #10 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 16'h1;
		if (cyc == 16'h0BB8) begin
			n_errors = n_errors + 1;
			summarize;
		end
	end
	task summarize;
		$display("errors=%0d checks=%0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input [33:0] g, input [33:0] e);
		checks_done = checks_done + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// single transfer; waits on hready, no fixed latency assumed
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge mclk);
		hsel   <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge mclk); while (hreadyout !== 1'h1);
		hsel   <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask
	task wr(input [7:0] a, input [31:0] d);
		bus(1'h1, a, d);
	endtask
	task rd(input [7:0] a, input [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(r, e);
	endtask
	function [33:0] txs(input q);
		txs = q ? {tx_resp_final, tx_resp_valid, tx_resp_data}
			: {tx_req_final, tx_req_valid, tx_req_data};
	endfunction
	task push(input q);
		@(posedge mclk) txr[q] <= 1'h1;
		@(posedge mclk) txr[q] <= 1'h0;
		@(negedge mclk) chk(txs(q) & 34'h100000000, 34'h0);
	endtask
	// reset values, write-only and unmapped reads, enable width
	task t_reset;
		rd(8'hA0, 32'h00000C00);
		rd(8'h98, 32'h0);
		rd(8'hA4, 32'h0);
		rd(8'h88, 32'h0);
		rd(8'hB0, 32'h0);
		wr(8'hA4, 32'hFFFFFFFF);
		rd(8'hA4, 32'h0001FFFF);
		wr(8'hA4, 32'h0);
		wr(8'hA0, 32'hFFFFFFFF);
		rd(8'hA0, 32'h0);
	endtask
	// load, write into a full register, push, final load
	task t_tx(input q, input [7:0] mid, input [7:0] fin);
		reg [31:0] d;
		d = {16'hC0DE, 15'h0, q};
		wr(mid, d);
		@(negedge mclk) chk(txs(q), {2'h1, d});
		wr(fin, ~d);
		@(negedge mclk) chk(txs(q), {2'h1, d});
		push(q);
		rd(8'hA0, 32'h5 << q);
		wr(8'hA0, 32'h4 << q);
		wr(fin, d + 32'h1);
		@(negedge mclk) chk(txs(q), {2'h3, d + 32'h1});
		rd(8'hA0, 32'h0);
		push(q);
		rd(8'hA0, 32'h1 << q);
		wr(8'hA0, 32'h1 << q);
	endtask
	// pop after bus reset, then a read blocked by a fault
	task t_rx(input q);
		reg [31:0] d;
		d = {16'h600D, 15'h0, q};
		@(posedge mclk) ev <= 11'h400;
		@(posedge mclk) ev <= 11'h0;
		wr(8'hA0, 32'hC00);
		@(posedge mclk) {rxd, rxf, sid, rxv[q]} <= {d, 3'h7};
		@(posedge mclk) rxv[q] <= 1'h0;
		@(negedge mclk) chk(rxr[q], 34'h0);
		rd(8'hA0, q ? 32'h2200 : 32'h5100);
		rd(8'h98 + {q, 2'h0}, d);
		chk(rxr[q], 34'h1);
		rd(8'hA0, 32'h0);
		@(posedge mclk) {ev, rxd, rxf, sid, rxv[q]} <= {11'h10 << q, ~d, 3'h1};
		@(posedge mclk) {ev, rxv[q]} <= 12'h0;
		rd(8'h98 + {q, 2'h0}, 32'h0);
		rd(8'hA0, 32'h500 << q);
		wr(8'hA0, 32'h400 << q);
		rd(8'h98 + {q, 2'h0}, ~d);
	endtask
	// every ev input except bus reset at once, masking and clearing
	task t_evt;
		wr(8'hA4, 32'h1FFFF);
		@(posedge mclk) ev <= 11'h3FF;
		@(posedge mclk) ev <= 11'h0;
		rd(8'hA0, 32'h18CFC);
		chk(irq, 34'h1);
		wr(8'hA4, 32'h0);
		repeat (2) @(posedge mclk);
		chk(irq, 34'h0);
		wr(8'hA4, 32'h1FFFF);
		wr(8'hA0, 32'h1FFFF);
		rd(8'hA0, 32'h0);
		repeat (2) @(posedge mclk);
		chk(irq, 34'h0);
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'h0;
		t_reset;
		t_tx(1'h0, 8'h88, 8'h8C);
		t_tx(1'h1, 8'h90, 8'h94);
		t_rx(1'h0);
		t_rx(1'h1);
		t_evt;
		summarize;
	end
endmodule // test_aqh_host_access
